// *** hdl/ccr_pkg.sv ***
// Overview of operation
// - Core rate equals 2M times input over 2N
// - Loop input is input clock, halved when enabled
// - Peripheral clock runs at half core rate
// - Memory clock ratio from control bits 20 to 18
// - Each serial clock divides core by own field
// - SPI clock divides core by baud value
// - Ratio pins set startup ratio during reset
// - Core reset holds 4096 input plus 2 core cycles
// - Late reset release may add one input cycle
// - Loop locks within 100 us at power-up
`default_nettype none
package ccr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 100;
  localparam int LOCK_TIME_US      = 100;
  localparam int LOCK_CYC          = LOCK_TIME_US * CLK_MHZ;
  localparam int LOCK_STABLE       = 4;
  localparam int CORE_RST_IN_CYC   = 4096;
  localparam int CORE_RST_CORE_CYC = 2;
  localparam int VCO_MAX_MHZ       = 800;
  localparam int SP_NUM            = 2;
  localparam int DIV_W             = 16;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PWR_OFS    = 8'h00;
  localparam logic [7:0] SDIV0_OFS  = 8'h04;
  localparam logic [7:0] SPIBR_OFS  = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  localparam int MULT_LSB  = 0;
  localparam int MULT_W    = 6;
  localparam int LDIV_LSB  = 6;
  localparam int LDIV_W    = 2;
  localparam int INDIV_BIT = 8;
  localparam int MEMR_LSB  = 18;
  localparam int MEMR_W    = 3;
  localparam logic [15:0] MEMR_BASE = 16'h0002;

  localparam logic [31:0] PWR_RST   = 32'h0000_0040;
  localparam logic [15:0] SDIV_RST  = 16'h0004;
  localparam logic [15:0] SPIBR_RST = 16'h0004;

  // Startup multiplier per ratio pin code
  localparam logic [5:0] STRAP_MULT [4] = '{6'h08, 6'h10, 6'h20, 6'h04};

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RR_HOLD  = 4'b0001,
    RR_COUNT = 4'b0010,
    RR_CORE  = 4'b0100,
    RR_RUN   = 4'b1000
  } ccr_rr_state_t;

  typedef struct packed {
    ccr_rr_state_t state;
    logic [12:0]   cnt;
    logic          rst;
  } ccr_rr_st_t;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } ccr_div_st_t;

  typedef struct packed {
    logic [2:0]                   clk_sy;
    logic [1:0]                   rst_sy;
    logic [1:0]                   cfg_s1;
    logic [1:0]                   cfg_s2;
    logic                         half;
    logic [15:0]                  per_cnt;
    logic [15:0]                  period;
    logic [2:0]                   stable;
    logic                         locked;
    logic [15:0]                  lock_cnt;
    logic                         lock_to;
    logic [31:0]                  acc;
    logic                         core_tick;
    logic [31:0]                  pwr;
    logic [SP_NUM-1:0][DIV_W-1:0] sdiv;
    logic [DIV_W-1:0]             spibr;
    logic                         ack;
    logic [31:0]                  rdata;
  } ccr_top_st_t;

endpackage
`default_nettype wire

// *** hdl/ccr_tick_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccr_tick_div (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       en_i,
  input  wire logic [ccr_pkg::DIV_W-1:0]  ratio_i,
  output logic                            tick_o
);

  ccr_pkg::ccr_div_st_t s_r;
  ccr_pkg::ccr_div_st_t s_nxt;
  logic [ccr_pkg::DIV_W-1:0] last;

  // ----------------------------------------------------------------
  // One tick every ratio enables; ratio zero acts as one
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    last = (ratio_i == '0) ? '0 : ratio_i - 1'b1;
    s_nxt.tick = 1'b0;
    if (en_i)
    begin
      if (s_r.cnt >= last)
      begin
        s_nxt.cnt = '0;
        s_nxt.tick = 1'b1;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick_o = s_r.tick;

endmodule
`default_nettype wire

// *** hdl/ccr_rst_release.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccr_rst_release #(
  parameter int N_IN = ccr_pkg::CORE_RST_IN_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_low_i,
  input  wire logic in_tick_i,
  input  wire logic core_tick_i,
  output logic      core_rst_o
);

  ccr_pkg::ccr_rr_st_t s_r;
  ccr_pkg::ccr_rr_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    unique case (s_r.state)
      ccr_pkg::RR_HOLD:
      begin
        s_nxt.cnt = '0;
        s_nxt.state = ccr_pkg::RR_COUNT;
      end
      ccr_pkg::RR_COUNT:
      begin
        if (in_tick_i)
        begin
          if (s_r.cnt == 13'(N_IN - 1))
          begin
            s_nxt.cnt = '0;
            s_nxt.state = ccr_pkg::RR_CORE;
          end
          else
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      ccr_pkg::RR_CORE:
      begin
        if (core_tick_i)
        begin
          if (s_r.cnt == 13'(ccr_pkg::CORE_RST_CORE_CYC - 1))
            s_nxt.state = ccr_pkg::RR_RUN;
          else
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      ccr_pkg::RR_RUN:
        s_nxt.state = ccr_pkg::RR_RUN;
      default:
        s_nxt.state = ccr_pkg::RR_HOLD;
    endcase
    if (pin_low_i)
    begin
      s_nxt.state = ccr_pkg::RR_HOLD;
      s_nxt.cnt = '0;
    end
    s_nxt.rst = (s_nxt.state != ccr_pkg::RR_RUN);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r.state <= ccr_pkg::RR_HOLD;
      s_r.cnt   <= '0;
      s_r.rst   <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign core_rst_o = s_r.rst;

endmodule
`default_nettype wire

// *** hdl/ccr_top.sv ***
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module ccr_top #(
  parameter int LOCK_CYC = ccr_pkg::LOCK_CYC,
  parameter int N_IN     = ccr_pkg::CORE_RST_IN_CYC
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       input_clock_i,
  input  wire logic                       reset_pin_n_i,
  input  wire logic [1:0]                 ratio_select_pins_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o,
  output logic                            core_tick_o,
  output logic                            periph_tick_o,
  output logic                            mem_tick_o,
  output logic [ccr_pkg::SP_NUM-1:0]      serial_tick_o,
  output logic                            spi_tick_o,
  output logic                            core_rst_o,
  output logic                            pll_locked_o
);

  ccr_pkg::ccr_top_st_t s_r;
  ccr_pkg::ccr_top_st_t s_nxt;

  logic        in_rise;
  logic        loop_tick;
  logic        pin_low;
  logic        req;
  logic [5:0]  mult;
  logic [1:0]  ldiv;
  logic [31:0] thr;
  logic [31:0] sum;
  logic [15:0] per_new;
  logic        close;
  logic        vco_over;
  logic [15:0] mem_ratio;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = dat[8*b +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Decoded fields
  // ----------------------------------------------------------------
  assign in_rise   = s_r.clk_sy[1] & ~s_r.clk_sy[2];
  assign pin_low   = ~s_r.rst_sy[1];
  assign req       = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign mult      = s_r.pwr[ccr_pkg::MULT_LSB +: ccr_pkg::MULT_W];
  assign ldiv      = s_r.pwr[ccr_pkg::LDIV_LSB +: ccr_pkg::LDIV_W];
  assign mem_ratio = 16'(s_r.pwr[ccr_pkg::MEMR_LSB +: ccr_pkg::MEMR_W])
                     + ccr_pkg::MEMR_BASE;
  // Loop input is every rising input edge, or every other one when halved
  assign loop_tick = in_rise & (~s_r.pwr[ccr_pkg::INDIV_BIT] | s_r.half);
  assign per_new   = s_r.per_cnt + 16'h0001;
  assign close     = (per_new == s_r.period) || (per_new == s_r.period + 16'h0001)
                     || (per_new + 16'h0001 == s_r.period);
  // Core ticks: 2M per cycle against 2N times the loop period
  assign thr = 32'(2 * ((ldiv == 2'h0) ? 2'h1 : ldiv)) * 32'(s_r.period);
  assign sum = s_r.acc + 32'(2 * mult);
  // Oscillator above maximum: 2*M*CLK_MHZ/P > VCO_MAX_MHZ
  assign vco_over = (32'(2 * ccr_pkg::CLK_MHZ) * 32'(mult))
                    > (32'(ccr_pkg::VCO_MAX_MHZ) * 32'(s_r.period));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.clk_sy = {s_r.clk_sy[1:0], input_clock_i};
    s_nxt.rst_sy = {s_r.rst_sy[0], reset_pin_n_i};
    s_nxt.cfg_s1 = ratio_select_pins_i;
    s_nxt.cfg_s2 = s_r.cfg_s1;
    s_nxt.core_tick = 1'b0;

    // Input divide stage
    if (in_rise)
      s_nxt.half = ~s_r.half;

    // Loop period measurement and lock
    if (loop_tick)
    begin
      s_nxt.per_cnt = '0;
      s_nxt.period = per_new;
      if (close)
      begin
        if (s_r.stable != 3'(ccr_pkg::LOCK_STABLE))
          s_nxt.stable = s_r.stable + 3'h1;
        else
          s_nxt.locked = 1'b1;
      end
      else
      begin
        s_nxt.stable = '0;
        s_nxt.locked = 1'b0;
      end
    end
    else if (s_r.per_cnt != 16'hFFFF)
      s_nxt.per_cnt = per_new;
    else
    begin
      s_nxt.stable = '0;
      s_nxt.locked = 1'b0;
    end

    // Lock watchdog
    if (!s_r.locked && !s_r.lock_to)
    begin
      if (s_r.lock_cnt == 16'(LOCK_CYC - 1))
        s_nxt.lock_to = 1'b1;
      else
        s_nxt.lock_cnt = s_r.lock_cnt + 16'h0001;
    end

    // Core clock synthesis
    if (s_r.locked)
    begin
      if (sum >= thr)
      begin
        s_nxt.core_tick = 1'b1;
        s_nxt.acc = (sum - thr >= thr) ? '0 : sum - thr;
      end
      else
        s_nxt.acc = sum;
    end
    else
      s_nxt.acc = '0;

    // Register bus
    s_nxt.ack = req;
    s_nxt.rdata = '0;
    if (req && wb_we_i)
    begin
      if (wb_adr_i == ccr_pkg::PWR_OFS)
        s_nxt.pwr = wmerge(s_r.pwr, wb_dat_i, wb_sel_i);
      if (wb_adr_i == ccr_pkg::SPIBR_OFS)
        s_nxt.spibr = 16'(wmerge({16'h0000, s_r.spibr}, wb_dat_i, wb_sel_i));
      for (int i = 0; i < ccr_pkg::SP_NUM; i++)
      begin
        if (wb_adr_i == ccr_pkg::SDIV0_OFS + 8'(4 * i))
          s_nxt.sdiv[i] = 16'(wmerge({16'h0000, s_r.sdiv[i]}, wb_dat_i, wb_sel_i));
      end
    end
    else if (req)
    begin
      if (wb_adr_i == ccr_pkg::PWR_OFS)
        s_nxt.rdata = s_r.pwr;
      if (wb_adr_i == ccr_pkg::SPIBR_OFS)
        s_nxt.rdata = {16'h0000, s_r.spibr};
      if (wb_adr_i == ccr_pkg::STATUS_OFS)
        s_nxt.rdata = {26'h000_0000, s_r.cfg_s2, vco_over, s_r.lock_to,
                       core_rst_o, s_r.locked};
      for (int i = 0; i < ccr_pkg::SP_NUM; i++)
      begin
        if (wb_adr_i == ccr_pkg::SDIV0_OFS + 8'(4 * i))
          s_nxt.rdata = {16'h0000, s_r.sdiv[i]};
      end
    end

    // Startup ratio follows the pins while reset is held
    if (pin_low)
    begin
      s_nxt.pwr[ccr_pkg::MULT_LSB +: ccr_pkg::MULT_W] = ccr_pkg::STRAP_MULT[s_r.cfg_s2];
      s_nxt.pwr[ccr_pkg::LDIV_LSB +: ccr_pkg::LDIV_W] = 2'h1;
      s_nxt.pwr[ccr_pkg::INDIV_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r       <= '0;
      s_r.pwr   <= ccr_pkg::PWR_RST;
      s_r.sdiv  <= {ccr_pkg::SP_NUM{ccr_pkg::SDIV_RST}};
      s_r.spibr <= ccr_pkg::SPIBR_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Derived clocks
  // ----------------------------------------------------------------
  ccr_tick_div u_periph (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (s_r.core_tick),
    .ratio_i (16'h0002),
    .tick_o  (periph_tick_o)
  );

  ccr_tick_div u_mem (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (s_r.core_tick),
    .ratio_i (mem_ratio),
    .tick_o  (mem_tick_o)
  );

  for (genvar g = 0; g < ccr_pkg::SP_NUM; g++)
  begin : g_sp
    ccr_tick_div u_sp (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .en_i    (s_r.core_tick),
      .ratio_i (s_r.sdiv[g]),
      .tick_o  (serial_tick_o[g])
    );
  end

  ccr_tick_div u_spi (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (s_r.core_tick),
    .ratio_i (s_r.spibr),
    .tick_o  (spi_tick_o)
  );

  // ----------------------------------------------------------------
  // Core reset release
  // ----------------------------------------------------------------
  ccr_rst_release #(
    .N_IN (N_IN)
  ) u_rr (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .pin_low_i   (pin_low),
    .in_tick_i   (in_rise),
    .core_tick_i (s_r.core_tick),
    .core_rst_o  (core_rst_o)
  );

  assign wb_dat_o     = s_r.rdata;
  assign wb_ack_o     = s_r.ack;
  assign core_tick_o  = s_r.core_tick;
  assign pll_locked_o = s_r.locked;

endmodule
`default_nettype wire

// *** test/ccr_board_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccr_board_model #(
  parameter int SETUP_CYC = 2000,
  parameter int VALID_CYC = 1000
) (
  input  wire logic       clk_i,
  input  wire logic       low_req_i,
  input  wire logic [1:0] pins_req_i,
  output logic            input_clock_o,
  output logic            reset_pin_n_o,
  output logic [1:0]      ratio_select_pins_o
);
  int ph = 0, held = 0, stab = 0, up = 0;
  initial
  begin
    input_clock_o = 1'h0;
    reset_pin_n_o = 1'h0;
    ratio_select_pins_o = 2'h0;
  end
  // Free running oscillator, 11 system clocks a period
  always @(posedge clk_i)
  begin
    ph <= (ph == 10) ? 0 : ph + 1;
    input_clock_o <= (ph < 6);
    up <= up + 1;
    stab <= (pins_req_i == ratio_select_pins_o) ? stab + 1 : 0;
    if (!reset_pin_n_o)
      ratio_select_pins_o <= pins_req_i;
    held <= reset_pin_n_o ? 0 : held + (ph == 0);
    if (low_req_i)
      reset_pin_n_o <= 1'h0;
    else if (held >= 4 && stab >= SETUP_CYC && up >= VALID_CYC)
      reset_pin_n_o <= 1'h1;
  end
endmodule
`default_nettype wire

// *** test/ccr_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccr_top_properties (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       reset_pin_n_i,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic                       core_tick_o,
  input wire logic                       periph_tick_o,
  input wire logic                       mem_tick_o,
  input wire logic [ccr_pkg::SP_NUM-1:0] serial_tick_o,
  input wire logic                       spi_tick_o,
  input wire logic                       core_rst_o,
  input wire logic                       pll_locked_o
);
  logic [1:0] pc_r;
  logic       cd_r;
  always_ff @(posedge clk_i)
  begin
    cd_r <= core_tick_o;
    pc_r <= (rst_i || periph_tick_o) ? 2'h0 : pc_r + {1'h0, cd_r};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one cycle answer");
  AST_DAT: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  AST_PERIPH: assert property (cd_r |-> periph_tick_o == (pc_r == 2'h1))
    else $error("peripheral tick not every second core tick");
  AST_MEM: assert property (mem_tick_o |-> $past(core_tick_o))
    else $error("memory tick without core tick");
  AST_SER: assert property (serial_tick_o != '0 |-> $past(core_tick_o))
    else $error("serial tick without core tick");
  AST_SPI: assert property (spi_tick_o |-> $past(core_tick_o))
    else $error("spi tick without core tick");
  AST_HOLD: assert property ((!reset_pin_n_i) [*4] |-> core_rst_o)
    else $error("core reset low while pin low");
  AST_EDGE: assert property ($fell(core_rst_o) |-> $past(core_tick_o))
    else $error("core reset released off a core tick");
  AST_LOCK: assert property (core_tick_o |-> pll_locked_o || $past(pll_locked_o))
    else $error("core tick while unlocked");
  AST_RST: assert property (disable iff (1'h0)
    rst_i |=> !wb_ack_o && core_rst_o && !pll_locked_o && !core_tick_o)
    else $error("outputs active after reset");
endmodule
bind ccr_top ccr_top_properties chk_u (.clk_i, .rst_i, .reset_pin_n_i, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .core_tick_o, .periph_tick_o, .mem_tick_o,
  .serial_tick_o, .spi_tick_o, .core_rst_o, .pll_locked_o);
`default_nettype wire

// *** test/ccr_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module ccr_top_tb;
  localparam int NI = 16;
  logic clk_i = 1'h0, rst_i = 1'h1, low_req = 1'h1, clr = 1'h0, ic_d = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rdat;
  logic [1:0] preq = 2'h0, ratio_select_pins_i, serial_tick_o;
  logic input_clock_i, reset_pin_n_i, wb_ack_o, core_tick_o, periph_tick_o;
  logic mem_tick_o, spi_tick_o, core_rst_o, pll_locked_o;
  logic [5:0] tk;
  int err_total = 0, samples_checked = 0, cyc_n = 0, ie = 0;
  int n [6] = '{default: 0};
  assign tk = {core_tick_o, periph_tick_o, mem_tick_o, serial_tick_o, spi_tick_o};
  ccr_top #(.LOCK_CYC(200), .N_IN(NI)) dut_u (.clk_i, .rst_i, .input_clock_i,
    .reset_pin_n_i, .ratio_select_pins_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .core_tick_o, .periph_tick_o,
    .mem_tick_o, .serial_tick_o, .spi_tick_o, .core_rst_o, .pll_locked_o);
  ccr_board_model #(.SETUP_CYC(20), .VALID_CYC(10)) brd_u (.clk_i, .low_req_i(low_req),
    .pins_req_i(preq), .input_clock_o(input_clock_i), .reset_pin_n_o(reset_pin_n_i),
    .ratio_select_pins_o(ratio_select_pins_i));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    ic_d <= input_clock_i;
    ie <= ie + (input_clock_i & ~ic_d);
    foreach (n[i]) n[i] <= clr ? 0 : n[i] + tk[i];
    if (cyc_n == 20000)
    begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, s, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'h1 && ++k < 50);
    rdat = wb_dat_o;
    `CHK(wb_ack_o, 1'h1)
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 4'hf, 32'h0000_0000);
    `CHK(rdat, e)
  endtask
  task automatic wait_in(input int e);
    int s;
    s = ie;
    while (ie - s < e) @(posedge clk_i);
  endtask
  task automatic clr_n();
    @(posedge clk_i) clr <= 1'h1;
    @(posedge clk_i) clr <= 1'h0;
  endtask
  task automatic t_lock();
    int k;
    k = 0;
    while (pll_locked_o !== 1'h1 && k++ < 200) @(posedge clk_i);
    `CHK(pll_locked_o, 1'h1)
    $display("lock test done");
  endtask
  task automatic t_regs();
    for (int c = 0; c < 4; c++)
    begin
      preq <= c[1:0];
      repeat (6) @(posedge clk_i);
      rd(ccr_pkg::STATUS_OFS, {26'h0, c[1:0], 4'h3});
      wb(1'h1, ccr_pkg::PWR_OFS, 4'hf, 32'h0000_013f);
      rd(ccr_pkg::PWR_OFS, {26'h0, ccr_pkg::STRAP_MULT[c]} | 32'h0000_0040);
    end
    preq <= 2'h0;
    rd(ccr_pkg::SDIV0_OFS, 32'h0000_0004);
    rd(ccr_pkg::SDIV0_OFS + 8'h04, 32'h0000_0004);
    rd(ccr_pkg::SPIBR_OFS, 32'h0000_0004);
    rd(8'h20, 32'h0000_0000);
    wb(1'h1, ccr_pkg::SDIV0_OFS, 4'h1, 32'h0000_1234);
    rd(ccr_pkg::SDIV0_OFS, 32'h0000_0034);
    $display("register test done");
  endtask
  task automatic t_release();
    int t0, k;
    low_req <= 1'h1;
    repeat (60) @(posedge clk_i);
    `CHK(core_rst_o, 1'h1)
    low_req <= 1'h0;
    k = 0;
    while (reset_pin_n_i !== 1'h1 && k++ < 500) @(posedge clk_i);
    t0 = cyc_n;
    while (core_rst_o !== 1'h0 && k++ < 1500) @(posedge clk_i);
    `CHK((cyc_n - t0) inside {[(NI - 1) * 11:(NI + 1) * 11 + 10]}, 1'h1)
    $display("release test done");
  endtask
  task automatic t_rate();
    logic [31:0] cfg [3];
    int e [3];
    // Multipliers keep the oscillator far below its maximum
    cfg = '{32'h0000_0048, 32'h0000_0084, 32'h0000_0148};
    e = '{80, 20, 40};
    for (int i = 0; i < 3; i++)
    begin
      wb(1'h1, ccr_pkg::PWR_OFS, 4'hf, cfg[i]);
      wait_in(20);
      clr_n();
      wait_in(10);
      `CHK(n[5] inside {[e[i] - 2:e[i] + 2]}, 1'h1)
    end
    $display("rate test done");
  endtask
  task automatic t_div();
    int e [5];
    e = '{30, 42, 210, 70, 105};
    wb(1'h1, ccr_pkg::PWR_OFS, 4'hf, 32'h0004_0048);
    wb(1'h1, ccr_pkg::SDIV0_OFS, 4'hf, 32'h0000_0005);
    wb(1'h1, ccr_pkg::SDIV0_OFS + 8'h04, 4'hf, 32'h0000_0000);
    wb(1'h1, ccr_pkg::SPIBR_OFS, 4'hf, 32'h0000_0007);
    wait_in(3);
    clr_n();
    while (n[5] < 210) @(posedge clk_i);
    @(posedge clk_i);
    for (int i = 0; i < 5; i++)
      `CHK(n[i] inside {[e[i] - 2:e[i] + 2]}, 1'h1)
    $display("divider test done");
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    t_lock();
    t_regs();
    t_release();
    t_rate();
    t_div();
    t_release();
    finish_test();
  end
endmodule
`default_nettype wire
